// *** bsdm_pkg.sv ***
// constants and types shared by the branch, skip and data-move executer
`default_nettype none
package bsdm_pkg;
	typedef enum logic [4:0] {
		OP_NOP           = 5'h00,
		OP_COMPARE_SKIP  = 5'h01,
		OP_COMPARE       = 5'h02,
		OP_COMPARE_CARRY = 5'h03,
		OP_COMPARE_IMM   = 5'h04,
		OP_SKIP_REG_CLR  = 5'h05,
		OP_SKIP_REG_SET  = 5'h06,
		OP_SKIP_IO_CLR   = 5'h07,
		OP_SKIP_IO_SET   = 5'h08,
		OP_BR_FLAG_SET   = 5'h09,
		OP_BR_FLAG_CLR   = 5'h0a,
		OP_BR_SIGNED_GE  = 5'h0b,
		OP_BR_SIGNED_LT  = 5'h0c,
		OP_COPY          = 5'h0d,
		OP_COPY_PAIR     = 5'h0e,
		OP_LOAD_IMM      = 5'h0f,
		OP_LOAD_DIRECT   = 5'h10,
		OP_LOAD_IND      = 5'h11,
		OP_STORE_DIRECT  = 5'h12,
		OP_STORE_IND     = 5'h13,
		OP_CALL          = 5'h14,
		OP_RETURN        = 5'h15,
		OP_INT_RETURN    = 5'h16
	} bsdm_op_type;

	typedef enum logic [1:0] {
		PTR_X = 2'h0,
		PTR_Y = 2'h1,
		PTR_Z = 2'h2
	} bsdm_ptr_type;

	typedef enum logic [1:0] {
		AM_PLAIN     = 2'h0,
		AM_POST_INC  = 2'h1,
		AM_PRE_DEC   = 2'h2,
		AM_DISPLACED = 2'h3
	} bsdm_mode_type;

	typedef enum logic [1:0] {
		ST_IDLE     = 2'h0,
		ST_BUSY     = 2'h1,
		ST_NVM_WAIT = 2'h3
	} bsdm_state_type;

	// status flag positions
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_I = 7;

	localparam logic [4:0]  PTR_X_LO = 5'h1a;
	localparam logic [4:0]  PTR_Y_LO = 5'h1c;
	localparam logic [4:0]  PTR_Z_LO = 5'h1e;
	localparam logic [4:0]  PAIR_HI  = 5'h01;

	localparam logic [2:0]  CYC_ONE          = 3'h1;
	localparam logic [2:0]  CYC_TAKEN        = 3'h2;
	localparam logic [2:0]  CYC_SKIP_ONE     = 3'h2;
	localparam logic [2:0]  CYC_SKIP_TWO     = 3'h3;
	localparam logic [2:0]  CYC_LOAD_DIRECT  = 3'h3;
	localparam logic [2:0]  CYC_LOAD_IND     = 3'h2;
	localparam logic [2:0]  CYC_STORE_DIRECT = 3'h2;
	localparam logic [2:0]  CYC_STORE_IND    = 3'h1;
	localparam logic [2:0]  CYC_CALL         = 3'h3;
	localparam logic [2:0]  CYC_RETURN       = 3'h4;
	localparam logic [1:0]  ACC_ONE          = 2'h1;
	localparam logic [1:0]  ACC_TWO          = 2'h2;

	localparam logic [15:0] PC_STEP_ONE = 16'h0001;
	localparam logic [15:0] PC_STEP_TWO = 16'h0002;
	localparam logic [15:0] PC_SKIP_ONE = 16'h0002;
	localparam logic [15:0] PC_SKIP_TWO = 16'h0003;
	localparam logic [15:0] PC_RESET    = 16'h0000;
	localparam logic [15:0] SP_RESET    = 16'h00ff;
	localparam logic [15:0] SP_PAIR     = 16'h0002;
	localparam logic [7:0]  FLAGS_RESET = 8'h00;
	// data space at or above this address goes through the nvm controller
	localparam logic [15:0] NVM_BASE    = 16'h1000;
endpackage
`default_nettype wire

// *** bsdm_exec.sv ***
// branch, compare, skip and data-move execution unit of an 8-bit core
`timescale 1ns/1ps
`default_nettype none
module bsdm_exec
	import bsdm_pkg::*;
(
	// clock and reset
	input  wire logic          clk_in,
	input  wire logic          reset_in,
	// decoded instruction
	input  wire logic          start_in,
	input  wire bsdm_op_type   op_in,
	input  wire logic [4:0]    rd_in,
	input  wire logic [4:0]    rr_in,
	input  wire logic [2:0]    bit_in,
	input  wire logic [7:0]    imm_in,
	input  wire logic [11:0]   rel_in,
	input  wire logic [15:0]   addr_in,
	input  wire bsdm_ptr_type  ptr_in,
	input  wire bsdm_mode_type mode_in,
	input  wire logic [5:0]    disp_in,
	input  wire logic          skip_two_in,
	// core state
	output logic               busy_out,
	output logic               done_out,
	output logic [15:0]        pc_out,
	output logic [15:0]        sp_out,
	output logic [7:0]         flags_out,
	input  wire logic [4:0]    view_index_in,
	output logic [7:0]         view_data_out,
	// single-cycle I/O bit access
	output logic [5:0]         io_addr_out,
	input  wire logic [7:0]    io_rdata_in,
	// data space
	output logic [15:0]        mem_addr_out,
	output logic [7:0]         mem_wdata_out,
	output logic               mem_read_out,
	output logic               mem_write_out,
	input  wire logic [7:0]    mem_rdata_in,
	input  wire logic          mem_ready_in
);
	logic [7:0]     regs [32];
	logic [15:0]    pc;
	logic [15:0]    sp;
	logic [7:0]     flags;
	bsdm_state_type state;
	logic [2:0]     cnt;
	logic [1:0]     acc_left;
	logic [15:0]    acc_addr;
	logic [7:0]     wdata;
	logic [7:0]     call_hi;
	logic [7:0]     ret_hi;
	bsdm_op_type    cur_op;
	logic [4:0]     dest;

	logic           accept;
	logic           acc_now;
	logic           is_nvm;
	logic           stall;
	logic           acc_done;
	logic           advance;
	logic [7:0]     rd_val;
	logic [7:0]     rr_val;
	logic [15:0]    ptr_val;
	logic [15:0]    eff_addr;
	logic [15:0]    next_ptr;
	logic           next_ptr_wr;
	logic [5:0]     next_cmp;
	logic           next_skip;
	logic           next_taken;
	logic [2:0]     next_cycles;
	logic [1:0]     next_acc;
	logic [15:0]    next_pc;
	logic [15:0]    next_addr;
	logic [7:0]     next_wdata;
	logic [15:0]    ret_pc;

	// subtract and return {H, S, V, N, Z, C}; z_keep chains Z for multi-byte
	function automatic logic [5:0] sub_flags(input logic [7:0] a,
			input logic [7:0] b, input logic cin, input logic z_keep);
		logic [7:0] r;
		logic       h;
		logic       v;
		logic       c;
		r = a - b - {7'h00, cin};
		h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
		v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
		c = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
		return {h, r[7] ^ v, v, r[7], (r == 8'h00) & z_keep, c};
	endfunction

	function automatic logic [4:0] ptr_lo(input bsdm_ptr_type p);
		unique case (p)
			PTR_X:   return PTR_X_LO;
			PTR_Y:   return PTR_Y_LO;
			default: return PTR_Z_LO;
		endcase
	endfunction

	function automatic logic is_branch(input bsdm_op_type o);
		return o inside {OP_BR_FLAG_SET, OP_BR_FLAG_CLR,
			OP_BR_SIGNED_GE, OP_BR_SIGNED_LT};
	endfunction

	assign accept      = start_in && (state == ST_IDLE);
	assign busy_out    = (state != ST_IDLE);
	assign pc_out      = pc;
	assign sp_out      = sp;
	assign flags_out   = flags;
	assign io_addr_out = addr_in[5:0];
	assign ret_pc      = pc + PC_STEP_TWO;

	// the accesses of an instruction fill its last cycles
	assign acc_now  = ((state == ST_BUSY) && (acc_left != 2'h0) &&
		({1'b0, acc_left} == cnt)) || (state == ST_NVM_WAIT);
	assign is_nvm   = (acc_addr >= NVM_BASE);
	assign stall    = (state == ST_BUSY) && acc_now && is_nvm;
	assign acc_done = ((state == ST_BUSY) && acc_now && !is_nvm) ||
		((state == ST_NVM_WAIT) && mem_ready_in);
	assign advance  = ((state == ST_BUSY) && !stall) ||
		((state == ST_NVM_WAIT) && mem_ready_in);
	assign done_out = advance && (cnt == CYC_ONE);
	// strobes follow the write flag; direction is fixed per instruction
	assign mem_write_out = acc_now && (cur_op inside {OP_STORE_DIRECT,
		OP_STORE_IND, OP_CALL});
	assign mem_read_out  = acc_now && !mem_write_out;
	assign mem_addr_out  = acc_addr;
	assign mem_wdata_out = wdata;

	always_comb begin
		rd_val      = regs[rd_in];
		rr_val      = regs[rr_in];
		ptr_val     = {regs[ptr_lo(ptr_in) | PAIR_HI], regs[ptr_lo(ptr_in)]};
		eff_addr    = ptr_val;
		next_ptr    = ptr_val;
		next_ptr_wr = 1'b0;
		unique case (mode_in)
			AM_POST_INC: begin
				next_ptr    = ptr_val + PC_STEP_ONE;
				next_ptr_wr = 1'b1;
			end
			AM_PRE_DEC: begin
				next_ptr    = ptr_val - PC_STEP_ONE;
				next_ptr_wr = 1'b1;
				eff_addr    = next_ptr;
			end
			AM_DISPLACED: begin
				// X has no displaced form, so it acts as plain
				if (ptr_in != PTR_X) begin
					eff_addr = ptr_val + {10'h000, disp_in};
				end
			end
			default: begin
			end
		endcase
		next_cmp    = sub_flags(rd_val, rr_val, 1'b0, 1'b1);
		next_skip   = 1'b0;
		next_taken  = 1'b0;
		next_cycles = CYC_ONE;
		next_acc    = 2'h0;
		next_pc     = pc + PC_STEP_ONE;
		next_addr   = eff_addr;
		next_wdata  = rr_val;
		unique case (op_in)
			OP_COMPARE_SKIP: next_skip = (rd_val == rr_val);
			OP_COMPARE_CARRY: next_cmp = sub_flags(rd_val, rr_val,
				flags[FLAG_C], flags[FLAG_Z]);
			OP_COMPARE_IMM: next_cmp = sub_flags(rd_val, imm_in, 1'b0,
				1'b1);
			OP_SKIP_REG_CLR: next_skip = !rr_val[bit_in];
			OP_SKIP_REG_SET: next_skip = rr_val[bit_in];
			OP_SKIP_IO_CLR:  next_skip = !io_rdata_in[bit_in];
			OP_SKIP_IO_SET:  next_skip = io_rdata_in[bit_in];
			// flag index picks carry, zero, negative, V, sign, half, T or I
			OP_BR_FLAG_SET: next_taken = flags[bit_in];
			OP_BR_FLAG_CLR: next_taken = !flags[bit_in];
			OP_BR_SIGNED_GE:
				next_taken = !(flags[FLAG_N] ^ flags[FLAG_V]);
			OP_BR_SIGNED_LT:
				next_taken = flags[FLAG_N] ^ flags[FLAG_V];
			OP_LOAD_DIRECT: begin
				next_cycles = CYC_LOAD_DIRECT;
				next_acc    = ACC_ONE;
				next_addr   = addr_in;
				next_pc     = pc + PC_STEP_TWO;
			end
			OP_LOAD_IND: begin
				next_cycles = CYC_LOAD_IND;
				next_acc    = ACC_ONE;
			end
			OP_STORE_DIRECT: begin
				next_cycles = CYC_STORE_DIRECT;
				next_acc    = ACC_ONE;
				next_addr   = addr_in;
				next_pc     = pc + PC_STEP_TWO;
			end
			OP_STORE_IND: begin
				next_cycles = CYC_STORE_IND;
				next_acc    = ACC_ONE;
			end
			OP_CALL: begin
				next_cycles = CYC_CALL;
				next_acc    = ACC_TWO;
				next_addr   = sp;
				next_wdata  = ret_pc[7:0];
				next_pc     = addr_in;
			end
			OP_RETURN, OP_INT_RETURN: begin
				next_cycles = CYC_RETURN;
				next_acc    = ACC_TWO;
				next_addr   = sp + PC_STEP_ONE;
			end
			default: begin
			end
		endcase
		if (next_skip) begin
			next_cycles = skip_two_in ? CYC_SKIP_TWO : CYC_SKIP_ONE;
			next_pc     = pc + (skip_two_in ? PC_SKIP_TWO : PC_SKIP_ONE);
		end
		if (next_taken) begin
			next_cycles = CYC_TAKEN;
			next_pc     = pc + {{4{rel_in[11]}}, rel_in} + PC_STEP_ONE;
		end
	end

	// register file: the moves land at acceptance, loads at their access
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			for (int i = 0; i < 32; i++) begin
				regs[i] <= 8'h00;
			end
		end else if (accept) begin
			unique case (op_in)
				OP_COPY:     regs[rd_in] <= rr_val;
				OP_LOAD_IMM: regs[rd_in] <= imm_in;
				OP_COPY_PAIR: begin
					regs[rd_in & ~PAIR_HI] <= regs[rr_in & ~PAIR_HI];
					regs[rd_in | PAIR_HI]  <= regs[rr_in | PAIR_HI];
				end
				OP_LOAD_IND, OP_STORE_IND: begin
					if (next_ptr_wr) begin
						regs[ptr_lo(ptr_in)]           <= next_ptr[7:0];
						regs[ptr_lo(ptr_in) | PAIR_HI] <= next_ptr[15:8];
					end
				end
				default: begin
				end
			endcase
		end else if (acc_done &&
				(cur_op inside {OP_LOAD_DIRECT, OP_LOAD_IND})) begin
			regs[dest] <= mem_rdata_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			view_data_out <= 8'h00;
		end else begin
			view_data_out <= regs[view_index_in];
		end
	end

	// only compares and the interrupt return touch the flags
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			flags <= FLAGS_RESET;
		end else if (accept && (op_in inside {OP_COMPARE, OP_COMPARE_CARRY,
				OP_COMPARE_IMM})) begin
			flags[5:0] <= next_cmp;
		end else if (done_out && (cur_op == OP_INT_RETURN)) begin
			flags[FLAG_I] <= 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			pc <= PC_RESET;
		end else if (accept && !(op_in inside {OP_RETURN, OP_INT_RETURN})) begin
			pc <= next_pc;
		end else if (acc_done && (acc_left == ACC_ONE) &&
				(cur_op inside {OP_RETURN, OP_INT_RETURN})) begin
			pc <= {ret_hi, mem_rdata_in};
		end
	end

	// return address goes low byte at sp, high byte at sp-1
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			sp <= SP_RESET;
		end else if (accept && (op_in == OP_CALL)) begin
			sp <= sp - SP_PAIR;
		end else if (accept && (op_in inside {OP_RETURN, OP_INT_RETURN})) begin
			sp <= sp + SP_PAIR;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			state    <= ST_IDLE;
			cnt      <= 3'h0;
			acc_left <= 2'h0;
			acc_addr <= 16'h0000;
			wdata    <= 8'h00;
			call_hi  <= 8'h00;
			ret_hi   <= 8'h00;
			cur_op   <= OP_NOP;
			dest     <= 5'h00;
		end else if (accept) begin
			state    <= ST_BUSY;
			cnt      <= next_cycles;
			acc_left <= next_acc;
			acc_addr <= next_addr;
			wdata    <= next_wdata;
			call_hi  <= ret_pc[15:8];
			cur_op   <= op_in;
			dest     <= rd_in;
		end else if (stall) begin
			state <= ST_NVM_WAIT;
		end else if (advance) begin
			cnt   <= cnt - CYC_ONE;
			state <= (cnt == CYC_ONE) ? ST_IDLE : ST_BUSY;
			if (acc_done) begin
				acc_left <= acc_left - ACC_ONE;
				acc_addr <= (cur_op == OP_CALL) ? acc_addr - PC_STEP_ONE :
					acc_addr + PC_STEP_ONE;
				wdata    <= call_hi;
				if (acc_left == ACC_TWO) begin
					ret_hi <= mem_rdata_in;
				end
			end
		end
	end

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (reset_in);

	sequence s_one_cycle;
		done_out ##1 !busy_out;
	endsequence
	sequence s_two_cycles;
		!done_out ##1 s_one_cycle;
	endsequence

	a_compare_flags: assert property (accept && (op_in inside {OP_COMPARE,
		OP_COMPARE_IMM}) |=> done_out && flags[5:0] == $past(next_cmp))
		else $error("compare flags or timing wrong");
	a_branch_taken: assert property (accept && is_branch(op_in) &&
		next_taken |=> s_two_cycles)
		else $error("taken branch not two cycles");
	a_branch_not_taken: assert property (accept && is_branch(op_in) &&
		!next_taken |=> pc == $past(pc) + PC_STEP_ONE ##0 s_one_cycle)
		else $error("untaken branch wrong");
	a_skip_two_words: assert property (accept && next_skip && skip_two_in
		|=> pc == $past(pc) + PC_SKIP_TWO ##0 !done_out ##1 s_two_cycles)
		else $error("two-word skip wrong");
	a_skip_one_word: assert property (accept && next_skip && !skip_two_in
		|=> s_two_cycles)
		else $error("one-word skip not two cycles");
	a_flags_kept: assert property (accept && !(op_in inside {OP_COMPARE,
		OP_COMPARE_CARRY, OP_COMPARE_IMM}) |=> flags == $past(flags))
		else $error("flags changed by non-compare");
	a_load_ram_time: assert property (accept && op_in == OP_LOAD_IND &&
		next_addr < NVM_BASE |=> !done_out ##1 done_out && mem_read_out)
		else $error("pointer load not two cycles");
	a_store_direct: assert property (accept && op_in == OP_STORE_DIRECT &&
		addr_in < NVM_BASE |=> !mem_write_out ##1 mem_write_out &&
		done_out)
		else $error("direct store timing wrong");
	a_nvm_extra: assert property (stall |-> !done_out ##1
		state == ST_NVM_WAIT && $stable(acc_addr))
		else $error("nvm access lacks extra cycle");
	a_post_increment: assert property (accept && op_in == OP_LOAD_IND &&
		mode_in == AM_POST_INC && ptr_lo(ptr_in) != (rd_in & ~PAIR_HI)
		|=> {regs[ptr_lo($past(ptr_in)) | PAIR_HI],
		regs[ptr_lo($past(ptr_in))]} == $past(ptr_val) + PC_STEP_ONE)
		else $error("pointer not incremented");
endmodule
`default_nettype wire

// *** bsdm_data_space.sv ***
// data space model: ram, a slow nvm window and the bit-addressable io space
`timescale 1ns/1ps
`default_nettype none
module bsdm_data_space
	import bsdm_pkg::*;
#(
	parameter int NVM_WAIT = 2
)(
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	// memory port
	input  wire logic [15:0] mem_addr_in,
	input  wire logic [7:0]  mem_wdata_in,
	input  wire logic        mem_read_in,
	input  wire logic        mem_write_in,
	output logic [7:0]       mem_rdata_out,
	output logic             mem_ready_out,
	// io bit space
	input  wire logic [5:0]  io_addr_in,
	output logic [7:0]       io_rdata_out
);
	logic [7:0] ram [0:511];
	logic [7:0] junk;
	logic [2:0] wait_count;
	logic       in_nvm;
	logic       access;
	logic       served;
	logic [8:0] index;

	assign in_nvm = mem_addr_in >= NVM_BASE;
	assign access = mem_read_in | mem_write_in;
	assign index = {in_nvm, mem_addr_in[7:0]};
	// nvm answers only after a few extra strobe cycles
	assign mem_ready_out = in_nvm && access && wait_count == 3'(NVM_WAIT);
	assign served = !in_nvm || mem_ready_out;
	// a moving pattern, so a stale read matches the right byte in only one cycle of 256
	assign mem_rdata_out = (mem_read_in && served) ? ram[index] : junk;
	assign io_rdata_out = {2'h2, io_addr_in};

	initial begin
		for (int i = 0; i < 512; i++) begin
			ram[i] = ~i[7:0];
		end
	end

	always @(posedge clk_in) begin
		if (mem_write_in && served) begin
			ram[index] <= mem_wdata_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in || !access || !in_nvm || mem_ready_out) begin
			wait_count <= 3'h0;
		end else begin
			wait_count <= wait_count + 3'h1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			junk <= 8'h3c;
		end else begin
			junk <= junk + 8'h5b;
		end
	end
endmodule
`default_nettype wire

// *** bsdm_exec_test.sv ***
// self-checking bench for the branch, skip and data-move executer
`timescale 1ns/1ps
`default_nettype none
module bsdm_exec_test
	import bsdm_pkg::*;
;
	typedef struct {
		bsdm_op_type op;
		logic [4:0]  rd, rr;
		logic [2:0]  bt;
		logic [15:0] k;
		logic [1:0]  pt, md;
		logic        two;
		logic [2:0]  n;
		logic [15:0] dpc;
		logic [4:0]  vi;
		logic [7:0]  vv, fl;
	} bsdm_row_type;

	logic clk_in, reset_in, start_in, skip_two_in;
	bsdm_op_type op_in;
	logic [4:0] rd_in, rr_in, view_index_in;
	logic [2:0] bit_in;
	logic [7:0] imm_in, view_data_out, flags_out, io_rdata_in;
	logic [11:0] rel_in;
	logic [15:0] addr_in, pc_out, sp_out, mem_addr_out, exp_pc, ret_pc;
	bsdm_ptr_type ptr_in;
	bsdm_mode_type mode_in;
	logic [5:0] disp_in, io_addr_out;
	logic busy_out, done_out, mem_read_out, mem_write_out, mem_ready_in;
	logic [7:0] mem_wdata_out, mem_rdata_in, cur_fl;
	int n_fail, num_checks, ncyc, cycles;
	bit tk;

	// op rd rr bit k ptr mode two cycles pc-step view-reg view-val flags
	bsdm_row_type rows [31] = '{
		'{OP_LOAD_IMM,16,0,0,16'h80,0,0,0,1,16'h1,16,8'h80,8'h0},
		'{OP_LOAD_IMM,17,0,0,16'h1,0,0,0,1,16'h1,17,8'h1,8'h0},
		'{OP_COMPARE,17,16,0,16'h0,0,0,0,1,16'h1,17,8'h1,8'hd},
		'{OP_BR_SIGNED_GE,0,0,0,16'h5,0,0,0,2,16'h6,17,8'h1,8'hd},
		'{OP_BR_SIGNED_LT,0,0,0,16'h5,0,0,0,1,16'h1,17,8'h1,8'hd},
		'{OP_COMPARE_IMM,16,0,0,16'h80,0,0,0,1,16'h1,16,8'h80,8'h2},
		'{OP_COMPARE_CARRY,17,16,0,16'h0,0,0,0,1,16'h1,16,8'h80,8'hd},
		'{OP_COMPARE_SKIP,16,16,0,16'h0,0,0,0,2,16'h2,16,8'h80,8'hd},
		'{OP_COMPARE_SKIP,16,16,0,16'h0,0,0,1,3,16'h3,16,8'h80,8'hd},
		'{OP_COMPARE_SKIP,16,17,0,16'h0,0,0,1,1,16'h1,16,8'h80,8'hd},
		'{OP_SKIP_REG_SET,0,16,7,16'h0,0,0,0,2,16'h2,16,8'h80,8'hd},
		'{OP_SKIP_REG_CLR,0,16,7,16'h0,0,0,0,1,16'h1,16,8'h80,8'hd},
		'{OP_SKIP_REG_CLR,0,16,0,16'h0,0,0,1,3,16'h3,16,8'h80,8'hd},
		'{OP_SKIP_IO_SET,0,0,7,16'h5,0,0,0,2,16'h2,16,8'h80,8'hd},
		'{OP_SKIP_IO_CLR,0,0,6,16'h5,0,0,1,3,16'h3,16,8'h80,8'hd},
		'{OP_SKIP_IO_SET,0,0,6,16'h5,0,0,0,1,16'h1,16,8'h80,8'hd},
		'{OP_COPY,18,16,0,16'h0,0,0,0,1,16'h1,18,8'h80,8'hd},
		'{OP_COPY_PAIR,2,16,0,16'h0,0,0,0,1,16'h1,3,8'h1,8'hd},
		'{OP_LOAD_IMM,28,0,0,16'h10,0,0,0,1,16'h1,28,8'h10,8'hd},
		'{OP_STORE_IND,0,16,0,16'h0,1,1,0,1,16'h1,28,8'h11,8'hd},
		'{OP_STORE_IND,0,17,0,16'h0,1,2,0,1,16'h1,28,8'h10,8'hd},
		'{OP_STORE_IND,0,16,0,16'h5,1,3,0,1,16'h1,28,8'h10,8'hd},
		'{OP_STORE_DIRECT,0,17,0,16'h20,0,0,0,2,16'h2,17,8'h1,8'hd},
		'{OP_LOAD_DIRECT,20,0,0,16'h20,0,0,0,3,16'h2,20,8'h1,8'hd},
		'{OP_LOAD_IND,21,0,0,16'h0,1,0,0,2,16'h1,21,8'h1,8'hd},
		'{OP_LOAD_IND,22,0,0,16'h5,1,3,0,2,16'h1,22,8'h80,8'hd},
		'{OP_LOAD_IND,23,0,0,16'h0,1,1,0,2,16'h1,23,8'h1,8'hd},
		'{OP_NOP,0,0,0,16'h0,0,0,0,1,16'h1,28,8'h11,8'hd},
		'{OP_LOAD_IND,24,0,0,16'h0,1,2,0,2,16'h1,24,8'h1,8'hd},
		'{OP_LOAD_IND,25,0,0,16'h5,0,3,0,2,16'h1,25,8'hff,8'hd},
		'{OP_LOAD_IND,26,0,0,16'h15,2,3,0,2,16'h1,26,8'h80,8'hd}
	};

	bsdm_exec dut (.clk_in(clk_in), .reset_in(reset_in), .start_in(start_in),
		.op_in(op_in), .rd_in(rd_in), .rr_in(rr_in), .bit_in(bit_in),
		.imm_in(imm_in), .rel_in(rel_in), .addr_in(addr_in), .ptr_in(ptr_in),
		.mode_in(mode_in), .disp_in(disp_in), .skip_two_in(skip_two_in),
		.busy_out(busy_out), .done_out(done_out), .pc_out(pc_out),
		.sp_out(sp_out), .flags_out(flags_out),
		.view_index_in(view_index_in), .view_data_out(view_data_out),
		.io_addr_out(io_addr_out), .io_rdata_in(io_rdata_in),
		.mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
		.mem_read_out(mem_read_out), .mem_write_out(mem_write_out),
		.mem_rdata_in(mem_rdata_in), .mem_ready_in(mem_ready_in));

	bsdm_data_space space (.clk_in(clk_in), .reset_in(reset_in),
		.mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out),
		.mem_read_in(mem_read_out), .mem_write_in(mem_write_out),
		.mem_rdata_out(mem_rdata_in), .mem_ready_out(mem_ready_in),
		.io_addr_in(io_addr_out), .io_rdata_out(io_rdata_in));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			n_fail++;
		end
	endtask

	task automatic end_of_test();
		$display("checks=%0d failures=%0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// hold keeps start up one busy edge longer, where it must be ignored
	task automatic run(input bsdm_row_type r, input bit hold);
		@(posedge clk_in);
		start_in <= 1'b1;
		op_in <= r.op;
		rd_in <= r.rd;
		rr_in <= r.rr;
		bit_in <= r.bt;
		imm_in <= r.k[7:0];
		rel_in <= r.k[11:0];
		addr_in <= r.k;
		ptr_in <= bsdm_ptr_type'(r.pt);
		mode_in <= bsdm_mode_type'(r.md);
		disp_in <= r.k[5:0];
		skip_two_in <= r.two;
		@(posedge clk_in);
		if (hold) begin
			@(posedge clk_in);
		end
		start_in <= 1'b0;
		ncyc = int'(hold) + 1;
		#1;
		while (done_out !== 1'b1 && ncyc < 20) begin
			@(posedge clk_in);
			#1;
			ncyc++;
		end
	endtask

	task automatic peek(input logic [4:0] idx, input logic [7:0] exp);
		@(posedge clk_in);
		view_index_in <= idx;
		@(posedge clk_in);
		#1;
		chk({8'h00, view_data_out}, {8'h00, exp});
	endtask

	task automatic do_row(input bsdm_row_type r, input bit hold = 1'b0);
		run(r, hold);
		chk(16'(ncyc), {13'h0, r.n});
		exp_pc = exp_pc + r.dpc;
		peek(r.vi, r.vv);
		chk(pc_out, exp_pc);
		chk({8'h00, flags_out}, {8'h00, r.fl});
	endtask

	task automatic chk_reset();
		chk({12'h000, busy_out, done_out, mem_read_out, mem_write_out}, 16'h0);
		chk(pc_out, PC_RESET);
		chk(sp_out, SP_RESET);
		chk({8'h00, flags_out}, {8'h00, FLAGS_RESET});
		exp_pc = PC_RESET;
	endtask

	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end

	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 6000) begin
			n_fail++;
			end_of_test();
		end
	end

	initial begin
		reset_in = 1'b1;
		start_in = 1'b0;
		op_in = OP_NOP;
		{rd_in, rr_in, bit_in, imm_in, rel_in, addr_in} = '0;
		{disp_in, skip_two_in, view_index_in} = '0;
		ptr_in = PTR_X;
		mode_in = AM_PLAIN;
		repeat (16) @(posedge clk_in);
		reset_in <= 1'b0;
		@(posedge clk_in);
		#1;
		chk_reset();
		foreach (rows[i]) begin
			do_row(rows[i]);
		end
		// subroutine entry and exit, the second exit also enabling interrupts
		for (int j = 0; j < 2; j++) begin
			ret_pc = exp_pc + 16'h0002;
			do_row('{OP_CALL,0,0,0,16'h40,0,0,0,3,
				16'h40 - exp_pc,16,8'h80,8'hd});
			chk(sp_out, 16'h00fd);
			cur_fl = (j == 1) ? 8'h8d : 8'h0d;
			do_row('{j ? OP_INT_RETURN : OP_RETURN,0,0,0,16'h0,0,0,0,4,
				ret_pc - exp_pc,16,8'h80,cur_fl});
			chk(sp_out, 16'h00ff);
		end
		// every flag, both senses, at the extreme offsets
		for (int b = 0; b < 16; b++) begin
			tk = (cur_fl[b % 8] == (b < 8));
			do_row('{b < 8 ? OP_BR_FLAG_SET : OP_BR_FLAG_CLR,0,0,3'(b % 8),
				b < 8 ? 16'h7ff : 16'h800,0,0,0,tk ? 3'h2 : 3'h1,
				tk ? (b < 8 ? 16'h800 : 16'hf801) : 16'h1,
				16,8'h80,cur_fl});
		end
		do_row('{OP_BR_FLAG_SET,0,0,7,16'h3,0,0,0,2,16'h4,16,8'h80,8'h8d},
			1'b1);
		do_row('{OP_LOAD_IMM,31,0,0,16'h10,0,0,0,1,16'h1,31,8'h10,8'h8d});
		run('{OP_STORE_IND,0,17,0,16'h0,2,0,0,1,16'h1,0,8'h0,8'h0}, 1'b0);
		chk(16'(ncyc inside {[2:5]}), 16'h1);
		run('{OP_LOAD_IND,27,0,0,16'h0,2,0,0,2,16'h1,0,8'h0,8'h0}, 1'b0);
		chk(16'(ncyc inside {[3:6]}), 16'h1);
		peek(27, 8'h01);
		// reset lands while a call is still busy
		@(posedge clk_in);
		op_in <= OP_CALL;
		start_in <= 1'b1;
		@(posedge clk_in);
		start_in <= 1'b0;
		reset_in <= 1'b1;
		@(posedge clk_in);
		reset_in <= 1'b0;
		@(posedge clk_in);
		#1;
		chk_reset();
		peek(16, 8'h00);
		end_of_test();
	end
endmodule
`default_nettype wire
